// *** src/swurp_device.sv ***
/*
  device end of the single wire uart register port: baud detect, datagram
  receive, crc check, reply with delay and turn-around, write counter.
  assumes register storage outside; rdata valid from the read pulse onward.
*/
// Notes on behaviour
// [R1] datagrams start sync nibble 1010, then address
// [R2] start low, stop high, lsb first
// [R3] bit time from start edge to bit3 edge
// [R4] master baud between 9000 and clk/16
// [R5] write datagram is eight bytes
// [R6] data word sent high byte first
// [R7] node address zero; act only when addressed, crc good
// [R8] read request is four bytes, flag clear
// [R9] reply: sync, 0xff, register byte, data, crc
// [R10] reply uses the request's baud rate
// [R11] reply waits programmable multiple of eight bits
// [R12] drive only while replying, release four bits later
// [R13] crc8 poly 0x07, seed zero, all bytes
// [R14] over 63 bits between starts resets reception
// [R15] idle pulse under 16 clocks is glitch
// [R16] crc or other error discards, then idle recovery
// [R17] master must not drop baud abruptly
// [R18] eight bit write counter, wraps, reads ignored
// [R19] line idles high between datagrams
// [R20] master disables pin power-down by register
// [R21] write register byte has top bit set
// [R22] delay field pairs map to odd multiples
// [R23] sample bits mid bit time
// [R24] sync upper nibble only feeds crc
`timescale 1ns/100ps
module swurp_device #(
  parameter logic [15:0] INIT_BIT_CYCLES = swurp_pkg::INIT_BIT
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  swurp_line_if.dev line_if,
  input wire logic [3:0] reply_delay_field_i,
  input wire logic [31:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [6:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  output logic [7:0] write_count_o
);
  import swurp_pkg::*;

  typedef enum logic [2:0] {D_IDLE, D_SYNC, D_RXBIT, D_GAP, D_DELAY, D_TX, D_TURN, D_RECOVER} swurp_dst_t;

  typedef struct packed {
    swurp_dst_t st;
    logic [2:0] sync;
    logic rx;
    logic rx_prev;
    logic [15:0] cnt;
    logic falls;
    logic [15:0] bit_len;
    logic [15:0] good;
    logic [3:0] idx;
    logic [7:0] shreg;
    logic [3:0] nbyte;
    logic [7:0] crc;
    logic addr_ok;
    logic [7:0] regb;
    logic [31:0] data;
    logic [15:0] to_cnt;
    logic [6:0] to_bits;
    logic [6:0] dcount;
    logic [9:0] txsh;
    logic [31:0] rdata;
    logic [6:0] addr;
    logic [31:0] wdata;
    logic [7:0] wcnt;
    logic wr;
    logic rd;
    logic out;
    logic oe;
  } swurp_dev_t;

  swurp_dev_t q;
  swurp_dev_t n;

  function automatic logic [7:0] reply_byte(input logic [3:0] i, input logic [6:0] a,
                                            input logic [31:0] d, input logic [7:0] c);
    unique case (i)
      4'h0: return SYNC_TX; // [R1]
      4'h1: return MASTER_ADDR; // [R9]
      4'h2: return {1'b0, a};
      4'h3: return d[31:24]; // [R6]
      4'h4: return d[23:16];
      4'h5: return d[15:8];
      4'h6: return d[7:0];
      default: return c; // [R13]
    endcase
  endfunction

  always_comb begin
    logic fall;
    logic tick;
    logic err;
    logic timeout;
    logic [7:0] b;
    logic [3:0] mult;
    logic [3:0] last;
    fall = 1'b0;
    tick = 1'b0;
    err = 1'b0;
    timeout = 1'b0;
    b = q.shreg;
    mult = 4'h1;
    last = q.regb[WR_FLAG_BIT] ? WR_LAST : RD_LAST; // [R5] [R8] [R21]
    n = q;
    n.wr = 1'b0;
    n.rd = 1'b0;
    n.sync = {q.sync[1:0], line_if.line};
    if (q.sync[2] == q.sync[1]) begin
      n.rx = q.sync[2];
    end
    n.rx_prev = q.rx;
    fall = q.rx_prev & ~q.rx;
    tick = (q.cnt == '0);
    // gap timer scaled by the last good datagram, not the current one
    timeout = (q.to_bits > GAP_MAX_BITS);
    if (q.st == D_RXBIT || q.st == D_GAP) begin
      if (q.to_cnt >= 16'(q.good - 16'h0001)) begin
        n.to_cnt = '0;
        if (!timeout) begin
          n.to_bits = q.to_bits + 7'h01;
        end
      end else begin
        n.to_cnt = q.to_cnt + 16'h0001;
      end
    end
    unique case (q.st)
      D_IDLE: begin
        if (fall) begin
          n.st = D_SYNC;
          // starts at one so three falls later the count is four whole bits
          n.cnt = 16'h0001;
          n.falls = 1'b0;
          n.to_cnt = '0;
          n.to_bits = '0;
        end
      end
      D_SYNC: begin
        n.cnt = q.cnt + 16'h0001;
        if (q.rx & ~q.rx_prev & (q.cnt < GLITCH_CYCLES)) begin
          err = 1'b1; // [R15]
        end
        if (&q.cnt) begin
          err = 1'b1;
        end
        if (fall) begin
          if (q.falls) begin
            // three falls span four bit times
            n.bit_len = {2'b00, q.cnt[15:2]}; // [R3] [R10]
            if ({2'b00, q.cnt[15:2]} < GLITCH_CYCLES) begin
              err = 1'b1; // [R4]
            end
            n.st = D_RXBIT;
            n.idx = SYNC_RESUME_IDX;
            n.shreg = SYNC_PRELOAD; // [R1]
            n.cnt = {3'b000, q.cnt[15:3]}; // [R23]
            n.nbyte = '0;
            n.crc = CRC_SEED;
          end else begin
            n.falls = 1'b1;
          end
        end
      end
      D_RXBIT: begin
        if (tick) begin
          n.cnt = 16'(q.bit_len - 16'h0001); // [R23]
          n.idx = q.idx + 4'h1;
          if (q.idx == START_IDX) begin
            if (q.rx) begin
              err = 1'b1; // [R2]
            end
          end else if (q.idx < STOP_IDX) begin
            n.shreg = {q.rx, q.shreg[7:1]}; // [R2]
          end else if (!q.rx) begin
            err = 1'b1; // [R16]
          end else begin
            if (q.nbyte == ADDR_BYTE) begin
              n.addr_ok = (b == NODE_ADDR); // [R7]
            end
            if (q.nbyte == REG_BYTE) begin
              n.regb = b;
            end
            if (q.nbyte >= DATA_BYTE) begin
              n.data = {q.data[23:0], b}; // [R6]
            end
            if (q.nbyte > REG_BYTE && q.nbyte == last) begin
              n.st = D_IDLE;
              if (b != q.crc) begin
                err = 1'b1; // [R13] [R16]
              end else if (q.addr_ok) begin
                n.good = q.bit_len;
                n.addr = q.regb[6:0];
                if (q.regb[WR_FLAG_BIT]) begin
                  n.wr = 1'b1;
                  n.wdata = q.data;
                  n.wcnt = q.wcnt + 8'h01; // [R18]
                end else begin
                  n.rd = 1'b1;
                  n.st = D_DELAY;
                  if (reply_delay_field_i >= 4'h2) begin
                    mult = reply_delay_field_i | 4'h1; // [R22]
                  end
                  n.dcount = 7'(mult) * DELAY_UNIT; // [R11]
                end
              end
            end else begin
              n.crc = crc8_byte(q.crc, b); // [R13] [R24]
              n.nbyte = q.nbyte + 4'h1;
              n.st = D_GAP;
            end
          end
        end else begin
          n.cnt = q.cnt - 16'h0001;
        end
        if (timeout) begin
          err = 1'b1; // [R14]
        end
      end
      D_GAP: begin
        if (timeout) begin
          err = 1'b1; // [R14]
        end else if (fall) begin
          n.st = D_RXBIT;
          n.idx = START_IDX;
          n.cnt = {1'b0, q.bit_len[15:1]};
          n.to_cnt = '0;
          n.to_bits = '0;
        end
      end
      D_DELAY: begin
        if (tick) begin
          n.cnt = 16'(q.bit_len - 16'h0001);
          n.dcount = q.dcount - 7'h01;
          if (q.dcount == 7'h01) begin
            b = reply_byte(4'h0, q.addr, q.rdata, q.crc);
            n.st = D_TX;
            n.nbyte = '0;
            n.idx = START_IDX;
            n.rdata = reg_rdata_i;
            n.crc = crc8_byte(CRC_SEED, b);
            n.txsh = {1'b1, b, 1'b0};
          end
        end else begin
          n.cnt = q.cnt - 16'h0001;
        end
      end
      D_TX: begin
        if (tick) begin
          n.cnt = 16'(q.bit_len - 16'h0001); // [R10]
          n.txsh = {1'b1, q.txsh[9:1]}; // [R2]
          n.idx = q.idx + 4'h1;
          if (q.idx == STOP_IDX) begin
            if (q.nbyte == WR_LAST) begin
              n.st = D_TURN;
              n.dcount = TURN_BITS; // [R12]
            end else begin
              b = reply_byte(q.nbyte + 4'h1, q.addr, q.rdata, q.crc); // [R9]
              n.txsh = {1'b1, b, 1'b0};
              n.idx = START_IDX;
              n.nbyte = q.nbyte + 4'h1;
              n.crc = crc8_byte(q.crc, b);
            end
          end
        end else begin
          n.cnt = q.cnt - 16'h0001;
        end
      end
      D_TURN: begin
        if (tick) begin
          n.cnt = 16'(q.bit_len - 16'h0001);
          n.dcount = q.dcount - 7'h01;
          if (q.dcount == 7'h01) begin
            n.st = D_IDLE; // [R12]
          end
        end else begin
          n.cnt = q.cnt - 16'h0001;
        end
      end
      D_RECOVER: begin
        // any low restarts the idle count
        if (!q.rx) begin
          n.cnt = '0;
        end else if (q.cnt >= 16'(q.good * RECOVER_BITS)) begin
          n.st = D_IDLE; // [R14] [R15] [R16]
        end else begin
          n.cnt = q.cnt + 16'h0001;
        end
      end
    endcase
    if (err) begin
      n.st = D_RECOVER;
      n.cnt = '0;
    end
    n.oe = (n.st == D_TX) || (n.st == D_TURN); // [R12]
    n.out = (n.st == D_TX) ? n.txsh[0] : 1'b1; // [R19]
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.sync <= 3'h7;
      q.rx <= 1'b1;
      q.rx_prev <= 1'b1;
      q.good <= INIT_BIT_CYCLES;
      q.bit_len <= INIT_BIT_CYCLES;
      q.out <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign line_if.dev_out = q.out;
  assign line_if.dev_oe = q.oe;
  assign reg_wr_o = q.wr;
  assign reg_rd_o = q.rd;
  assign reg_addr_o = q.addr;
  assign reg_wdata_o = q.wdata;
  assign write_count_o = q.wcnt;
endmodule

// *** src/swurp_pkg.sv ***
/*
  constants, shared crc function for the single wire uart register port.
  assumes both ends run on one 20 mhz core clock.
*/
package swurp_pkg;
  localparam int unsigned CLK_HZ = 32'h0131_2d00;
  localparam int unsigned MIN_BAUD = 32'h0000_2328;
  // slowest legal bit in cycles, rounded down
  localparam logic [15:0] INIT_BIT = 16'(CLK_HZ / MIN_BAUD);
  localparam logic [15:0] DEF_BAUD_DIV = 16'h0040;
  localparam logic [3:0] SYNC_NIBBLE = 4'h5;
  localparam logic [7:0] SYNC_TX = 8'h05;
  localparam logic [7:0] SYNC_PRELOAD = 8'ha0;
  localparam logic [7:0] NODE_ADDR = 8'h00;
  localparam logic [7:0] MASTER_ADDR = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;
  localparam int WR_FLAG_BIT = 7;
  localparam logic [3:0] ADDR_BYTE = 4'h1;
  localparam logic [3:0] REG_BYTE = 4'h2;
  localparam logic [3:0] DATA_BYTE = 4'h3;
  localparam logic [3:0] RD_LAST = 4'h3;
  localparam logic [3:0] WR_LAST = 4'h7;
  localparam logic [3:0] START_IDX = 4'h0;
  localparam logic [3:0] STOP_IDX = 4'h9;
  localparam logic [3:0] SYNC_RESUME_IDX = 4'h4;
  localparam logic [6:0] GAP_MAX_BITS = 7'h3f;
  localparam logic [15:0] RECOVER_BITS = 16'h000c;
  localparam logic [15:0] GLITCH_CYCLES = 16'h0010;
  localparam logic [6:0] TURN_BITS = 7'h04;
  localparam logic [6:0] DELAY_UNIT = 7'h08;
  localparam logic [6:0] GUARD_BITS = 7'h10;
  localparam logic [7:0] REPLY_WAIT_BITS = 8'hc8;

  // lsb first, seed and poly as above
  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[7] ^ b[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction
endpackage

// *** src/swurp_line_if.sv ***
/*
  shared single data line between master and device.
  assumes a pull-up: the line is low only while an enabled driver drives low.
*/
`timescale 1ns/100ps
interface swurp_line_if;
  logic host_out;
  logic host_oe;
  logic dev_out;
  logic dev_oe;
  logic line;

  assign line = ~((host_oe & ~host_out) | (dev_oe & ~dev_out));

  modport host (output host_out, output host_oe, input line);
  modport dev (output dev_out, output dev_oe, input line);
endinterface

// *** src/swurp_host.sv ***
/*
  master end: command fifo, datagram sender, reply receiver with crc check.
  assumes one device on the line; depth of the fifo a power of two.
*/
`timescale 1ns/100ps
module swurp_fifo #(
  parameter int W = 40,
  parameter int D = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } swurp_fifo_t;

  swurp_fifo_t q;
  swurp_fifo_t n;
  logic full;
  logic empty;

  assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign empty = (q.wp == q.rp);
  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o = q.mem[q.rp[AW-1:0]];

  always_comb begin
    n = q;
    if (in_valid_i && !full) begin
      n.mem[q.wp[AW-1:0]] = in_data_i;
      n.wp = q.wp + 1'b1;
    end
    if (out_ready_i && !empty) begin
      n.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

module swurp_host #(
  parameter logic [15:0] BAUD_DIV = swurp_pkg::DEF_BAUD_DIV,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  swurp_line_if.host line_if,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic [6:0] cmd_addr_i,
  input wire logic [31:0] cmd_data_i,
  output logic rsp_valid_o,
  output logic rsp_ok_o,
  output logic [31:0] rsp_data_o,
  output logic busy_o
);
  import swurp_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_TX, H_WAIT, H_RX, H_GUARD} swurp_hst_t;

  typedef struct packed {
    swurp_hst_t st;
    logic [2:0] sync;
    logic rx;
    logic rx_prev;
    logic [15:0] cnt;
    logic [3:0] idx;
    logic [9:0] txsh;
    logic [7:0] shreg;
    logic [3:0] nbyte;
    logic wr;
    logic [6:0] addr;
    logic [31:0] data;
    logic [7:0] crc;
    logic [7:0] wt;
    logic [6:0] dcount;
    logic ok;
    logic rsp_valid;
    logic rsp_ok;
    logic [31:0] rsp_data;
    logic out;
    logic oe;
  } swurp_host_t;

  swurp_host_t q;
  swurp_host_t n;
  logic pop_valid;
  logic pop_ready;
  logic [39:0] pop_data;

  // stalls the user while a datagram is in flight and the queue is full
  swurp_fifo #(.W(40), .D(FIFO_DEPTH)) u_cmd_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(cmd_valid_i),
    .in_ready_o(cmd_ready_o),
    .in_data_i({cmd_write_i, cmd_addr_i, cmd_data_i}),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_data)
  );

  assign pop_ready = (q.st == H_IDLE);

  function automatic logic [7:0] host_byte(input logic [3:0] i, input logic w, input logic [6:0] a,
                                           input logic [31:0] d, input logic [7:0] c);
    if (i == (w ? WR_LAST : RD_LAST)) begin
      return c; // [R13]
    end
    unique case (i)
      4'h0: return SYNC_TX; // [R1]
      4'h1: return NODE_ADDR;
      4'h2: return {w, a}; // [R21] [R8]
      4'h3: return d[31:24]; // [R6]
      4'h4: return d[23:16];
      4'h5: return d[15:8];
      default: return d[7:0];
    endcase
  endfunction

  always_comb begin
    logic tick;
    logic [7:0] b;
    tick = (q.cnt == '0);
    b = q.shreg;
    n = q;
    n.rsp_valid = 1'b0;
    n.sync = {q.sync[1:0], line_if.line};
    if (q.sync[2] == q.sync[1]) begin
      n.rx = q.sync[2];
    end
    n.rx_prev = q.rx;
    if (q.st != H_IDLE) begin
      n.cnt = tick ? 16'(BAUD_DIV - 16'h0001) : 16'(q.cnt - 16'h0001); // [R4]
    end
    unique case (q.st)
      H_IDLE: begin
        if (pop_valid) begin
          b = host_byte(4'h0, pop_data[39], pop_data[38:32], pop_data[31:0], CRC_SEED);
          n.wr = pop_data[39];
          n.addr = pop_data[38:32];
          n.data = pop_data[31:0];
          n.st = H_TX;
          n.cnt = 16'(BAUD_DIV - 16'h0001);
          n.idx = START_IDX;
          n.nbyte = '0;
          n.crc = crc8_byte(CRC_SEED, b);
          n.txsh = {1'b1, b, 1'b0}; // [R2]
        end
      end
      H_TX: begin
        if (tick) begin
          n.txsh = {1'b1, q.txsh[9:1]};
          n.idx = q.idx + 4'h1;
          if (q.idx == STOP_IDX) begin
            if (q.nbyte == (q.wr ? WR_LAST : RD_LAST)) begin // [R5] [R8]
              n.st = q.wr ? H_GUARD : H_WAIT;
              n.dcount = GUARD_BITS;
              n.wt = REPLY_WAIT_BITS;
              n.nbyte = '0;
              n.ok = 1'b1;
            end else begin
              b = host_byte(q.nbyte + 4'h1, q.wr, q.addr, q.data, q.crc);
              n.txsh = {1'b1, b, 1'b0};
              n.idx = START_IDX;
              n.nbyte = q.nbyte + 4'h1;
              n.crc = crc8_byte(q.crc, b);
            end
          end
        end
      end
      H_WAIT: begin
        if (q.rx_prev & ~q.rx) begin
          n.st = H_RX;
          n.idx = START_IDX;
          n.cnt = {1'b0, BAUD_DIV[15:1]};
          if (q.nbyte == '0) begin
            n.crc = CRC_SEED;
          end
        end else if (tick) begin
          n.wt = q.wt - 8'h01;
          if (q.wt == 8'h01) begin
            n.rsp_valid = 1'b1;
            n.rsp_ok = 1'b0;
            n.st = H_GUARD;
            n.dcount = GUARD_BITS;
          end
        end
      end
      H_RX: begin
        if (tick) begin
          n.idx = q.idx + 4'h1;
          if (q.idx > START_IDX && q.idx < STOP_IDX) begin
            n.shreg = {q.rx, q.shreg[7:1]}; // [R2]
          end else if (q.idx == STOP_IDX) begin
            n.st = H_WAIT;
            n.wt = REPLY_WAIT_BITS;
            n.nbyte = q.nbyte + 4'h1;
            n.crc = crc8_byte(q.crc, b); // [R13]
            if ((q.nbyte == 4'h0 && b[3:0] != SYNC_NIBBLE) || (q.nbyte == ADDR_BYTE && b != MASTER_ADDR) ||
                (q.nbyte == REG_BYTE && b != {1'b0, q.addr}) || !q.rx) begin
              n.ok = 1'b0; // [R1] [R9]
            end
            if (q.nbyte >= DATA_BYTE) begin
              n.rsp_data = {q.rsp_data[23:0], b}; // [R6]
            end
            if (q.nbyte == WR_LAST) begin
              n.rsp_data = q.rsp_data;
              n.rsp_valid = 1'b1;
              n.rsp_ok = q.ok && (b == q.crc);
              n.st = H_GUARD;
              n.dcount = GUARD_BITS;
            end
          end
        end
      end
      H_GUARD: begin
        // lets the device finish its turn-around before we drive again
        if (tick) begin
          n.dcount = q.dcount - 7'h01;
          if (q.dcount == 7'h01) begin
            n.st = H_IDLE;
          end
        end
      end
    endcase
    n.oe = (n.st == H_TX);
    n.out = (n.st == H_TX) ? n.txsh[0] : 1'b1; // [R19]
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.sync <= 3'h7;
      q.rx <= 1'b1;
      q.rx_prev <= 1'b1;
      q.out <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign line_if.host_out = q.out;
  assign line_if.host_oe = q.oe;
  assign rsp_valid_o = q.rsp_valid;
  assign rsp_ok_o = q.rsp_ok;
  assign rsp_data_o = q.rsp_data;
  assign busy_o = (q.st != H_IDLE);
endmodule

// *** verification/swurp_line_asserts.sv ***
/*
  checks on the shared line between host and device.
  assumes both ends use BIT cycles a bit.
*/
`timescale 1ns/100ps
module swurp_line_asserts #(
  parameter int BIT = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic line
);
  logic [15:0] pos_q, quiet_q, hi_q;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // quiet saturates so a long idle never wraps
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_q <= '0;
      quiet_q <= '0;
      hi_q <= '0;
    end else begin
      pos_q <= host_oe ? pos_q + 16'h0001 : '0;
      quiet_q <= host_oe ? '0 : quiet_q + {15'h0000, ~&quiet_q};
      hi_q <= (dev_oe && dev_out) ? hi_q + 16'h0001 : '0;
    end
  end
  property p_start;
    $rose(host_oe) |-> !host_out [*8];
  endproperty
  a_start: assert property (p_start) else $error("short host start bit");
  property p_edge;
    host_oe && $changed(host_out) |-> pos_q % BIT == 0;
  endproperty
  a_edge: assert property (p_edge) else $error("host edge off grid");
  property p_stop;
    $fell(host_oe) |-> $past(host_out);
  endproperty
  a_stop: assert property (p_stop) else $error("host released low");
  property p_dlow;
    dev_oe && $fell(dev_out) |-> !dev_out [*8];
  endproperty
  a_dlow: assert property (p_dlow) else $error("short device low bit");
  property p_clash;
    !(host_oe && dev_oe);
  endproperty
  a_clash: assert property (p_clash) else $error("both ends drive");
  property p_turn;
    $rose(dev_oe) |-> quiet_q >= 16'(7 * BIT);
  endproperty
  a_turn: assert property (p_turn) else $error("reply too early");
  property p_release;
    $fell(dev_oe) |-> hi_q >= 16'(5 * BIT - 4);
  endproperty
  a_release: assert property (p_release) else $error("device released early");
  property p_idle;
    !host_oe && !dev_oe |-> line;
  endproperty
  a_idle: assert property (p_idle) else $error("idle line low");
  c_reply: cover property ($rose(dev_oe));
  c_host: cover property ($fell(host_oe));
  c_back: cover property ($fell(host_oe) ##[1:1000] $rose(host_oe));
endmodule

// *** verification/swurp_tb_top.sv ***
/*
  bench: host and device on one line, a second device on a hand-driven
  line for fault cases. assumes 20 mhz clock, host bit of 16 cycles.
*/
`timescale 1ns/100ps
`define CHK(x, y) \
  begin \
    compares++; \
    if ((x) !== (y)) begin \
      miscompares++; \
      $display("mismatch t=%0t got %h exp %h", $time, x, y); \
    end \
  end
module swurp_tb_top;
  localparam int BIT = 16;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [31:0] cmd_data = 32'h0000_0000;
  logic [3:0] reply_delay_field = 4'h0;
  logic cmd_ready, rsp_valid, rsp_ok, busy, wr0, rd0;
  logic [31:0] rsp_data, wdata0;
  logic [6:0] addr0;
  logic [7:0] cnt0, cnt1;
  logic [31:0] mem [128] = '{default: 32'h0000_0000};
  logic [7:0] q[$];
  int st[$];
  int cyc = 0, rsp_n = 0, rd_n = 0, first_st = 0, last_st = 0, b1 = 20;
  int miscompares = 0, compares = 0;
  swurp_line_if line0();
  swurp_line_if line1();
  swurp_host #(.BAUD_DIV(16'h0010), .FIFO_DEPTH(8)) swurp_host_inst (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .line_if(line0), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .rsp_valid_o(rsp_valid),
    .rsp_ok_o(rsp_ok), .rsp_data_o(rsp_data), .busy_o(busy));
  swurp_device #(.INIT_BIT_CYCLES(16'h0040)) swurp_device_inst (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .line_if(line0), .reply_delay_field_i(reply_delay_field),
    .reg_rdata_i(mem[addr0]), .reg_wr_o(wr0), .reg_rd_o(rd0), .reg_addr_o(addr0),
    .reg_wdata_o(wdata0), .write_count_o(cnt0));
  swurp_device #(.INIT_BIT_CYCLES(16'h0040)) swurp_device_inst2 (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .line_if(line1), .reply_delay_field_i(reply_delay_field), .reg_rdata_i(32'h0000_0000),
    .reg_wr_o(), .reg_rd_o(), .reg_addr_o(), .reg_wdata_o(), .write_count_o(cnt1));
  swurp_line_asserts #(.BIT(BIT)) swurp_line_asserts_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .host_out(line0.host_out), .host_oe(line0.host_oe), .dev_out(line0.dev_out),
    .dev_oe(line0.dev_oe), .line(line0.line));
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (rsp_valid === 1'b1) rsp_n <= rsp_n + 1;
    if (rd0 === 1'b1) rd_n <= rd_n + 1;
    if (wr0 === 1'b1) mem[addr0] <= wdata0;
  end
  function automatic logic [6:0] wa(input int i);
    return (i == 8) ? 7'h7f : 7'(i * 13);
  endfunction
  function automatic logic [31:0] wd(input int i);
    return 32'h8765_4321 + 32'(i) * 32'h0101_0101;
  endfunction
  function automatic logic [7:0] tcrc(input logic [7:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c[7] ^ b[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction
  // line monitor decodes every byte at the host's bit time
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge line0.line);
      st.push_back(cyc);
      repeat (BIT / 2) @(posedge core_clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge core_clk_i);
        b[i] = line0.line;
      end
      repeat (BIT) @(posedge core_clk_i);
      `CHK(line0.line, 1'b1)
      q.push_back(b);
    end
  end
  task automatic frame(input logic [7:0] ad, input logic [7:0] r, input logic [31:0] dt, input int n);
    logic [7:0] e[8];
    logic [7:0] b;
    e[0] = 8'h05;
    e[1] = ad;
    e[2] = r;
    for (int k = 3; k < n - 1; k++) e[k] = dt[8 * (6 - k) +: 8];
    e[n - 1] = 8'h00;
    for (int k = 0; k < n - 1; k++) e[n - 1] = tcrc(e[n - 1], e[k]);
    for (int k = 0; k < n; k++) begin
      for (int t = 0; t < 9000 && q.size() == 0; t++) @(posedge core_clk_i);
      b = (q.size() > 0) ? q.pop_front() : 8'hxx;
      last_st = (st.size() > 0) ? st.pop_front() : 0;
      if (k == 0) first_st = last_st;
      `CHK(b, e[k])
    end
  endtask
  // caller drops valid
  task automatic push(input logic w, input logic [6:0] ad, input logic [31:0] dt);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= ad;
    cmd_data <= dt;
    do @(posedge core_clk_i); while (cmd_ready !== 1'b1);
  endtask
  task automatic dg1(input logic [7:0] s, input logic [7:0] ad, input logic [7:0] bad, input int gap);
    logic [7:0] e[8];
    logic [9:0] f;
    e = '{s, ad, 8'h85, 8'h11, 8'h22, 8'h33, 8'h44, 8'h00};
    for (int k = 0; k < 7; k++) e[7] = tcrc(e[7], e[k]);
    e[7] = e[7] ^ bad;
    line1.host_oe <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (k == 4) repeat (gap) @(posedge core_clk_i);
      f = {1'b1, e[k], 1'b0};
      for (int i = 0; i < 10; i++) begin
        line1.host_out <= f[i];
        repeat (b1) @(posedge core_clk_i);
      end
    end
    line1.host_oe <= 1'b0;
    repeat (16 * b1) @(posedge core_clk_i);
  endtask
  task automatic results();
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge core_clk_i);
    miscompares++;
    results();
  end
  initial begin
    int s;
    int n;
    line1.host_oe = 1'b0;
    line1.host_out = 1'b1;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    for (int i = 0; i < 9; i++) push(1'b1, wa(i), wd(i));
    @(negedge core_clk_i);
    `CHK(cmd_ready, 1'b0)
    `CHK(busy, 1'b1)
    @(posedge core_clk_i);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 9; i++) frame(8'h00, {1'b1, wa(i)}, wd(i), 8);
    repeat (2 * BIT) @(posedge core_clk_i);
    `CHK(cnt0, 8'h09)
    `CHK(addr0, wa(8))
    `CHK(wdata0, wd(8))
    for (int k = 0; k < 16; k++) begin
      reply_delay_field <= 4'(k);
      push(1'b0, wa(k % 9), 32'h0000_0000);
      cmd_valid <= 1'b0;
      frame(8'h00, {1'b0, wa(k % 9)}, 32'h0000_0000, 4);
      s = last_st + 9 * BIT + BIT / 2;
      frame(8'hff, {1'b0, wa(k % 9)}, wd(k % 9), 8);
      n = (k < 2) ? 1 : (k | 1);
      `CHK(first_st >= s + n * 128 - 4 && first_st <= s + n * 128 + 12, 1'b1)
      for (int t = 0; t < 1000 && rsp_n <= k; t++) @(posedge core_clk_i);
      `CHK(rsp_ok, 1'b1)
      `CHK(rsp_data, wd(k % 9))
      repeat (8 * BIT) @(posedge core_clk_i);
    end
    `CHK(cnt0, 8'h09)
    `CHK(rd_n, 16)
    dg1(8'h05, 8'h00, 8'h01, 0);
    repeat (800) @(posedge core_clk_i);
    `CHK(busy, 1'b0)
    `CHK(cnt1, 8'h00)
    dg1(8'h05, 8'h00, 8'h00, 0);
    `CHK(cnt1, 8'h01)
    dg1(8'h05, 8'h01, 8'h00, 0);
    `CHK(cnt1, 8'h01)
    // glitch, then a datagram at once
    line1.host_oe <= 1'b1;
    line1.host_out <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    line1.host_out <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    dg1(8'h05, 8'h00, 8'h00, 0);
    `CHK(cnt1, 8'h01)
    repeat (300) @(posedge core_clk_i);
    dg1(8'h05, 8'h00, 8'h00, 1400);
    `CHK(cnt1, 8'h01)
    repeat (300) @(posedge core_clk_i);
    b1 = 24;
    dg1(8'ha5, 8'h00, 8'h00, 0);
    `CHK(cnt1, 8'h02)
    results();
  end
endmodule
